// ==== hps_pkg.sv ====
package hps_pkg;

	// ************************************************************
	// identification channel addresses
	// ************************************************************
	localparam logic [7:0] IDENT_ADDR_NEW = 8'hA2; // newer block
	localparam logic [7:0] IDENT_ADDR_OLD = 8'hA0; // older block

	// ************************************************************
	// interface selections
	// ************************************************************
	localparam logic [1:0] SEL_NONE    = 2'h0;
	localparam logic [1:0] SEL_DIGITAL = 2'h1;
	localparam logic [1:0] SEL_ANALOG  = 2'h2;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_HZ           = 10000000;
	localparam int DEBOUNCE_US      = 10;
	localparam int DEBOUNCE_CYCLES  = DEBOUNCE_US * (CLK_HZ / 1000000);

endpackage

// ==== hps_sense_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// presence bit passed from conditioner to sequencer
// ************************************************************
interface hps_sense_if;
	logic present;
	logic rise;
	logic fall;
	modport src (output present, output rise, output fall);
	modport dst (input present, input rise, input fall);
endinterface
`default_nettype wire

// ==== hps_presence.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// charge power presence: synchronise, debounce, edge detect
// ************************************************************
module hps_presence #(
	parameter int DEB_CYCLES = hps_pkg::DEBOUNCE_CYCLES
) (
	// clock and reset
	input  wire logic    clk,
	input  wire logic    rst,
	// comparator pin
	input  wire logic    cp_above_pin,
	// conditioned presence
	hps_sense_if.src     sense
);
	localparam int CW = $clog2(DEB_CYCLES + 1);

	logic          sync1_ff;
	logic          sync2_ff;
	logic          stable_ff;
	logic          rise_ff;
	logic          fall_ff;
	logic [CW-1:0] cnt_ff;
	logic          nxt_stable;
	logic          nxt_rise;
	logic          nxt_fall;
	logic [CW-1:0] nxt_cnt;

	// debounce: accept a new level after it stays DEB_CYCLES
	always_comb begin
		nxt_stable = stable_ff;
		nxt_rise   = 1'b0;
		nxt_fall   = 1'b0;
		nxt_cnt    = '0;
		if (sync2_ff != stable_ff) begin
			if (cnt_ff == CW'(DEB_CYCLES - 1)) begin
				nxt_stable = sync2_ff;
				nxt_rise   = sync2_ff;
				nxt_fall   = ~sync2_ff;
			end else begin
				nxt_cnt = cnt_ff + CW'(1);
			end
		end
	end

	// two-stage synchroniser and debounce registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_ff  <= 1'b0;
			sync2_ff  <= 1'b0;
			stable_ff <= 1'b0;
			rise_ff   <= 1'b0;
			fall_ff   <= 1'b0;
			cnt_ff    <= '0;
		end else begin
			sync1_ff  <= cp_above_pin;
			sync2_ff  <= sync1_ff;
			stable_ff <= nxt_stable;
			rise_ff   <= nxt_rise;
			fall_ff   <= nxt_fall;
			cnt_ff    <= nxt_cnt;
		end
	end

	assign sense.present = stable_ff;
	assign sense.rise    = rise_ff;
	assign sense.fall    = fall_ff;

	// ************************************************************
	// checks
	// ************************************************************
	a_rise_level: assert property (@(posedge clk) disable iff (rst)
		rise_ff |-> stable_ff)
		else $error("rise without presence");
	a_fall_level: assert property (@(posedge clk) disable iff (rst)
		fall_ff |-> !stable_ff)
		else $error("fall with presence");
endmodule
`default_nettype wire

// ==== hps_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - after reset, read ident block at A2h before any video output
// - digital selected: enable transmitter only with charge power present
// - analogue selected: enable converters, drive image from fetched data
// - digital run: power loss disables transmitter at once
// - after detach, transmitter stays off; power return asks for re-identify
// - analogue run: power loss does not stop converters
// - analogue run: power onset disables converters, asks re-identify
// - no block at A2h: assume analogue, try old block at A0h
// - old block present: configure output, then enable converters
// - no block at all: enable converters, sense load on three colours
// - not all loaded: sense green, assume monochrome either way
// - unidentified monitor: converters run without power, watch for onset
// - new attach raises a notification pulse for re-identification
// - power watch and shutdown run in hardware without software
module hps_sequencer #(
	parameter int DEB_CYCLES = hps_pkg::DEBOUNCE_CYCLES
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// charge power comparator, high at or above threshold
	input  wire logic       cp_above_pin,
	// identification channel fetch engine
	output logic            ident_req,
	output logic [7:0]      ident_addr,
	input  wire logic       ident_done,
	input  wire logic       ident_found,
	input  wire logic       ident_digital,
	// output configuration from software/engine
	output logic            cfg_req,
	input  wire logic       cfg_done,
	// load sense of analogue outputs
	output logic            load_req,
	output logic            load_green_only,
	input  wire logic       load_done,
	input  wire logic       load_seen,
	// video enables
	output logic            digital_serial_video_en,
	output logic            analogue_video_dacs_en,
	// status
	output logic [1:0]      mon_kind,
	output logic            reident_irq
);
	// ************************************************************
	// presence conditioning
	// ************************************************************
	hps_sense_if sense ();

	hps_presence #(.DEB_CYCLES(DEB_CYCLES)) u_presence (
		.clk          (clk),
		.rst          (rst),
		.cp_above_pin (cp_above_pin),
		.sense        (sense)
	);

	// ************************************************************
	// sequencer states
	// ************************************************************
	typedef enum logic [10:0] {
		ST_FETCH_NEW = 11'h001,
		ST_FETCH_OLD = 11'h002,
		ST_CFG       = 11'h004,
		ST_LOAD_ALL  = 11'h008,
		ST_LOAD_G    = 11'h010,
		ST_CHK_PWR   = 11'h020,
		ST_RUN_DIG   = 11'h040,
		ST_RUN_ANA   = 11'h080,
		ST_DETACHED  = 11'h100,
		ST_WAIT_SW   = 11'h200,
		ST_START     = 11'h400
	} hps_state_type;

	hps_state_type state_ff;
	hps_state_type nxt_state;
	logic          sel_digital_ff;
	logic          nxt_sel_digital;
	logic          ireq_ff;
	logic          nxt_ireq;
	logic [7:0]    iaddr_ff;
	logic [7:0]    nxt_iaddr;
	logic          creq_ff;
	logic          nxt_creq;
	logic          lreq_ff;
	logic          nxt_lreq;
	logic          lg_ff;
	logic          nxt_lg;
	logic          dig_ff;
	logic          nxt_dig;
	logic          dac_ff;
	logic          nxt_dac;
	logic [1:0]    kind_ff;
	logic [1:0]    nxt_kind;
	logic          irq_ff;
	logic          nxt_irq;

	// next-state and output logic
	always_comb begin
		nxt_state       = state_ff;
		nxt_sel_digital = sel_digital_ff;
		nxt_ireq        = 1'b0;
		nxt_iaddr       = iaddr_ff;
		nxt_creq        = 1'b0;
		nxt_lreq        = 1'b0;
		nxt_lg          = lg_ff;
		nxt_dig         = dig_ff;
		nxt_dac         = dac_ff;
		nxt_kind        = kind_ff;
		nxt_irq         = 1'b0;
		case (state_ff)
			ST_START: begin
				nxt_ireq  = 1'b1;
				nxt_iaddr = hps_pkg::IDENT_ADDR_NEW;
				nxt_dig   = 1'b0;
				nxt_dac   = 1'b0;
				nxt_kind  = hps_pkg::SEL_NONE;
				nxt_state = ST_FETCH_NEW;
			end
			ST_FETCH_NEW: begin
				if (ident_done) begin
					if (ident_found && ident_digital) begin
						nxt_sel_digital = 1'b1;
						nxt_kind        = hps_pkg::SEL_DIGITAL;
						nxt_state       = ST_CHK_PWR;
					end else if (ident_found) begin
						nxt_sel_digital = 1'b0;
						nxt_kind        = hps_pkg::SEL_ANALOG;
						nxt_creq        = 1'b1;
						nxt_state       = ST_CFG;
					end else begin
						nxt_sel_digital = 1'b0;
						nxt_kind        = hps_pkg::SEL_ANALOG;
						nxt_ireq        = 1'b1;
						nxt_iaddr       = hps_pkg::IDENT_ADDR_OLD;
						nxt_state       = ST_FETCH_OLD;
					end
				end
			end
			ST_FETCH_OLD: begin
				if (ident_done) begin
					if (ident_found) begin
						nxt_creq  = 1'b1;
						nxt_state = ST_CFG;
					end else begin
						nxt_dac   = 1'b1;
						nxt_lreq  = 1'b1;
						nxt_lg    = 1'b0;
						nxt_state = ST_LOAD_ALL;
					end
				end
			end
			ST_LOAD_ALL: begin
				if (load_done) begin
					if (load_seen) begin
						nxt_creq  = 1'b1;
						nxt_state = ST_CFG;
					end else begin
						nxt_lreq  = 1'b1;
						nxt_lg    = 1'b1;
						nxt_state = ST_LOAD_G;
					end
				end
			end
			ST_LOAD_G: begin
				if (load_done) begin
					nxt_lg    = 1'b0;
					nxt_creq  = 1'b1;
					nxt_state = ST_CFG;
				end
			end
			ST_CFG: begin
				if (cfg_done) begin
					nxt_dac   = 1'b1;
					nxt_state = ST_RUN_ANA;
				end
			end
			ST_CHK_PWR: begin
				if (sense.present) begin
					nxt_dig   = 1'b1;
					nxt_state = ST_RUN_DIG;
				end
			end
			ST_RUN_DIG: begin
				if (!sense.present) begin
					nxt_dig   = 1'b0;
					nxt_state = ST_DETACHED;
				end
			end
			ST_DETACHED: begin
				if (sense.rise) begin
					nxt_irq   = 1'b1;
					nxt_state = ST_WAIT_SW;
				end
			end
			ST_RUN_ANA: begin
				// a power loss is ignored: converters keep running
				if (sense.rise) begin
					nxt_dac   = 1'b0;
					nxt_irq   = 1'b1;
					nxt_state = ST_WAIT_SW;
				end
			end
			ST_WAIT_SW: begin
				nxt_state = ST_START; // rerun identification
			end
			default: begin
				nxt_state = ST_START;
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff       <= ST_START;
			sel_digital_ff <= 1'b0;
			ireq_ff        <= 1'b0;
			iaddr_ff       <= hps_pkg::IDENT_ADDR_NEW;
			creq_ff        <= 1'b0;
			lreq_ff        <= 1'b0;
			lg_ff          <= 1'b0;
			dig_ff         <= 1'b0;
			dac_ff         <= 1'b0;
			kind_ff        <= hps_pkg::SEL_NONE;
			irq_ff         <= 1'b0;
		end else begin
			state_ff       <= nxt_state;
			sel_digital_ff <= nxt_sel_digital;
			ireq_ff        <= nxt_ireq;
			iaddr_ff       <= nxt_iaddr;
			creq_ff        <= nxt_creq;
			lreq_ff        <= nxt_lreq;
			lg_ff          <= nxt_lg;
			dig_ff         <= nxt_dig;
			dac_ff         <= nxt_dac;
			kind_ff        <= nxt_kind;
			irq_ff         <= nxt_irq;
		end
	end

	assign ident_req               = ireq_ff;
	assign ident_addr              = iaddr_ff;
	assign cfg_req                 = creq_ff;
	assign load_req                = lreq_ff;
	assign load_green_only         = lg_ff;
	assign digital_serial_video_en = dig_ff;
	assign analogue_video_dacs_en  = dac_ff;
	assign mon_kind                = kind_ff;
	assign reident_irq             = irq_ff;

	// ************************************************************
	// checks
	// ************************************************************
	a_first_fetch_new: assert property (@(posedge clk) disable iff (rst)
		(ireq_ff && $past(state_ff) == ST_START)
		|-> iaddr_ff == hps_pkg::IDENT_ADDR_NEW)
		else $error("first fetch not at new address");
	a_dig_needs_pwr: assert property (@(posedge clk) disable iff (rst)
		$rose(dig_ff) |-> sense.present)
		else $error("transmitter on without power");
	a_ana_after_cfg: assert property (@(posedge clk) disable iff (rst)
		(state_ff == ST_CFG && cfg_done) |=> dac_ff)
		else $error("converters not on after config");
	a_dig_off_loss: assert property (@(posedge clk) disable iff (rst)
		(state_ff == ST_RUN_DIG && !sense.present) |=> !dig_ff)
		else $error("transmitter not off on loss");
	a_no_reenable: assert property (@(posedge clk) disable iff (rst)
		state_ff == ST_DETACHED |=> !dig_ff)
		else $error("transmitter re-enabled after detach");
	a_ana_keeps_on: assert property (@(posedge clk) disable iff (rst)
		(state_ff == ST_RUN_ANA && !sense.rise) |=> dac_ff)
		else $error("converters dropped without onset");
	a_ana_onset_off: assert property (@(posedge clk) disable iff (rst)
		(state_ff == ST_RUN_ANA && sense.rise)
		|=> (!dac_ff && irq_ff) ##1 ireq_ff == 1'b0)
		else $error("onset did not stop converters");
	a_fallback_old: assert property (@(posedge clk) disable iff (rst)
		(state_ff == ST_FETCH_NEW && ident_done && !ident_found)
		|=> ireq_ff && iaddr_ff == hps_pkg::IDENT_ADDR_OLD)
		else $error("no fallback to old address");
	a_green_mono: assert property (@(posedge clk) disable iff (rst)
		(state_ff == ST_LOAD_ALL && load_done && !load_seen)
		|=> lreq_ff && lg_ff)
		else $error("green sense not started");
	a_irq_pulse: assert property (@(posedge clk) disable iff (rst)
		irq_ff |=> !irq_ff ##1 ireq_ff)
		else $error("notification not followed by refetch");
	a_load_dacs_on: assert property (@(posedge clk) disable iff (rst)
		(lreq_ff && !lg_ff) |-> dac_ff)
		else $error("load sense without converters");
	a_cfg_before_dacs: assert property (@(posedge clk) disable iff (rst)
		(state_ff == ST_FETCH_OLD && ident_done && ident_found)
		|=> creq_ff && !dac_ff)
		else $error("converters on before config");

	c_dig_run: cover property (@(posedge clk) disable iff (rst)
		state_ff == ST_RUN_DIG);
	c_dig_detach: cover property (@(posedge clk) disable iff (rst)
		state_ff == ST_DETACHED ##1 irq_ff);
	c_ana_onset: cover property (@(posedge clk) disable iff (rst)
		state_ff == ST_RUN_ANA && sense.rise);
	c_green_path: cover property (@(posedge clk) disable iff (rst)
		state_ff == ST_LOAD_G && load_done);
endmodule
`default_nettype wire

// ==== hps_mon_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// far side model: attached monitor and its identification store
// ************************************************************
module hps_mon_model (
	// clock
	input  wire logic       clk,
	// scenario setup
	input  wire logic       has_new,
	input  wire logic       new_digital,
	input  wire logic       has_old,
	input  wire logic       all_loaded,
	input  wire logic [1:0] lat,
	// requests from the sequencer
	input  wire logic       ident_req,
	input  wire logic [7:0] ident_addr,
	input  wire logic       cfg_req,
	input  wire logic       load_req,
	input  wire logic       load_green_only,
	// answers
	output logic            ident_done,
	output logic            ident_found,
	output logic            ident_digital,
	output logic            cfg_done,
	output logic            load_done,
	output logic            load_seen
);
	logic f;
	logic d;
	logic s;
	logic is_new;

	// answers outside a done pulse show the inverse, never a stale match
	assign ident_found   = ident_done ? f : ~f;
	assign ident_digital = ident_done ? d : ~d;
	assign load_seen     = load_done ? s : ~s;
	assign is_new        = (ident_addr === hps_pkg::IDENT_ADDR_NEW);

	initial begin
		ident_done = 1'h0;
		cfg_done = 1'h0;
		load_done = 1'h0;
		f = 1'h0;
		d = 1'h0;
		s = 1'h0;
	end

	// identification fetch answered after lat cycles
	always @(posedge clk) begin
		if (ident_req === 1'h1) begin
			f = is_new ? has_new : has_old;
			d = is_new & new_digital;
			repeat (lat) @(posedge clk);
			ident_done <= 1'h1;
			@(posedge clk);
			ident_done <= 1'h0;
		end
	end

	// output configuration completes after lat cycles
	always @(posedge clk) begin
		if (cfg_req === 1'h1) begin
			repeat (lat) @(posedge clk);
			cfg_done <= 1'h1;
			@(posedge clk);
			cfg_done <= 1'h0;
		end
	end

	// load sense; a green-only probe finds nothing in this model
	always @(posedge clk) begin
		if (load_req === 1'h1) begin
			s = all_loaded & ~load_green_only;
			repeat (lat) @(posedge clk);
			load_done <= 1'h1;
			@(posedge clk);
			load_done <= 1'h0;
		end
	end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int DEB = 2;
	localparam int DIG = 0;
	localparam int DAC = 1;
	localparam int REQ = 2;
	localparam int CFG = 3;
	localparam int LOAD = 4;
	localparam int IRQ = 5;
	logic       clk;
	logic       rst;
	logic       cp;
	logic       has_new, new_digital, has_old, all_loaded;
	logic [1:0] lat;
	logic       ident_req, ident_done, ident_found, ident_digital;
	logic       cfg_req, cfg_done, load_req, green, load_done, load_seen;
	logic       dig_en, dacs_en, irq;
	logic [7:0] ident_addr;
	logic [1:0] mon_kind;
	logic [5:0] watch;
	int         failures = 0;
	int         total_checks = 0;
	int         n;

	assign watch = {irq, load_req, cfg_req, ident_req, dacs_en, dig_en};

	// ************************************************************
	// clock, design and far side
	// ************************************************************
	initial clk = 1'h0;
	always #50 clk = ~clk;

	hps_sequencer #(.DEB_CYCLES(DEB)) u_dut (.clk(clk), .rst(rst),
		.cp_above_pin(cp), .ident_req(ident_req), .ident_addr(ident_addr),
		.ident_done(ident_done), .ident_found(ident_found),
		.ident_digital(ident_digital), .cfg_req(cfg_req),
		.cfg_done(cfg_done), .load_req(load_req), .load_green_only(green),
		.load_done(load_done), .load_seen(load_seen),
		.digital_serial_video_en(dig_en), .analogue_video_dacs_en(dacs_en),
		.mon_kind(mon_kind), .reident_irq(irq));

	hps_mon_model u_mon (.clk(clk), .has_new(has_new),
		.new_digital(new_digital), .has_old(has_old),
		.all_loaded(all_loaded), .lat(lat), .ident_req(ident_req),
		.ident_addr(ident_addr), .cfg_req(cfg_req), .load_req(load_req),
		.load_green_only(green), .ident_done(ident_done),
		.ident_found(ident_found), .ident_digital(ident_digital),
		.cfg_done(cfg_done), .load_done(load_done), .load_seen(load_seen));

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// bounded wait on one watched output, n counts the negedges passed
	task automatic wt(input int sel, input logic v, output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (watch[sel] !== v && n < 300);
		chk("waited output", 8'(v), 8'(watch[sel]));
	endtask

	task automatic do_reset(input logic nw, input logic dg, input logic od,
		input logic al, input logic c);
		@(posedge clk);
		rst <= 1'h1;
		has_new <= nw;
		new_digital <= dg;
		has_old <= od;
		all_loaded <= al;
		cp <= c;
		repeat (6) @(posedge clk);
		rst <= 1'h0;
	endtask

	// set charge power pin to v on the next rising edge: high for attach, low for detach
	task automatic setcp(input logic v);
		@(posedge clk);
		cp <= v;
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic s_digital;
		lat <= 2'h0;
		do_reset(1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
		wt(REQ, 1'h1, n);
		chk("ident_addr", hps_pkg::IDENT_ADDR_NEW, ident_addr);
		chk("dacs_en", 8'h0, dacs_en);
		repeat (20) @(negedge clk);
		chk("dig_en unpowered", 8'h0, dig_en);
		chk("mon_kind", hps_pkg::SEL_DIGITAL, mon_kind);
		setcp(1'h1);
		wt(DIG, 1'h1, n);
		setcp(1'h0);
		wt(DIG, 1'h0, n);
		chk("loss latency ok", 8'h1, n <= DEB + 6);
		setcp(1'h1);
		wt(IRQ, 1'h1, n);
		chk("dig_en at attach", 8'h0, dig_en);
		wt(REQ, 1'h1, n);
		chk("restart gap ok", 8'h1, n <= 2);
		chk("dig_en at restart", 8'h0, dig_en);
	endtask

	task automatic s_analogue;
		lat <= 2'h3;
		do_reset(1'h1, 1'h0, 1'h0, 1'h0, 1'h1);
		wt(DAC, 1'h1, n);
		chk("dig_en", 8'h0, dig_en);
		chk("mon_kind", hps_pkg::SEL_ANALOG, mon_kind);
		setcp(1'h0);
		repeat (20) @(negedge clk);
		chk("dacs_en after loss", 8'h1, dacs_en);
		setcp(1'h1);
		wt(IRQ, 1'h1, n);
		chk("dacs_en at onset", 8'h0, dacs_en);
		chk("onset latency ok", 8'h1, n <= DEB + 6);
	endtask

	task automatic s_old;
		lat <= 2'h1;
		do_reset(1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
		wt(REQ, 1'h1, n);
		wt(REQ, 1'h0, n);
		wt(REQ, 1'h1, n);
		chk("ident_addr", hps_pkg::IDENT_ADDR_OLD, ident_addr);
		chk("mon_kind", hps_pkg::SEL_ANALOG, mon_kind);
		wt(CFG, 1'h1, n);
		chk("dacs_en at cfg", 8'h0, dacs_en);
		wt(DAC, 1'h1, n);
	endtask

	task automatic s_legacy;
		for (int al = 1; al >= 0; al--) begin
			lat <= 2'h2;
			do_reset(1'h0, 1'h0, 1'h0, al[0], 1'h0);
			wt(LOAD, 1'h1, n);
			chk("dacs_en at sense", 8'h1, dacs_en);
			chk("green_only", 8'h0, green);
			if (al == 0) begin
				wt(LOAD, 1'h0, n);
				wt(LOAD, 1'h1, n);
				chk("green_only", 8'h1, green);
			end
			wt(CFG, 1'h1, n);
			repeat (20) @(negedge clk);
			chk("dacs_en unpowered", 8'h1, dacs_en);
			chk("mon_kind", hps_pkg::SEL_ANALOG, mon_kind);
			setcp(1'h1);
			wt(IRQ, 1'h1, n);
			chk("dacs_en at onset", 8'h0, dacs_en);
		end
	endtask

	// ************************************************************
	// verdict, watchdog and main sequence
	// ************************************************************
	task automatic close_out;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		#500000;
		failures++;
		$display("Error watchdog expected finish seen hang");
		close_out;
	end

	initial begin
		rst = 1'h1;
		cp = 1'h0;
		lat = 2'h0;
		has_new = 1'h0;
		new_digital = 1'h0;
		has_old = 1'h0;
		all_loaded = 1'h0;
		s_digital;
		s_analogue;
		s_old;
		s_legacy;
		close_out;
	end
endmodule
`default_nettype wire
